// >>> rtl/lhf_pkg.sv
// shared constants and types of the layer 2 frame header filter
package lhf_pkg;
    localparam int ENTRY_NUM = 128;
    localparam int ID_W = 8;
    localparam int MAC_W = 48;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int VE_MAX = 8;
    localparam logic [ADDR_W-1:0] REG_GLOBAL = 12'h000;
    localparam logic [ADDR_W-1:0] REG_STATUS = 12'h001;
    localparam logic [ADDR_W-1:0] REG_STAGE_PORT = 12'h002;
    localparam logic [ADDR_W-1:0] REG_STAGE_CTRL = 12'h003;
    localparam logic [ADDR_W-1:0] REG_FRAMES = 12'h004;
    localparam logic [ADDR_W-1:0] REG_DROPS = 12'h005;
    localparam logic [ADDR_W-1:0] REG_STAGE_ID = 12'h010;
    localparam logic [ADDR_W-1:0] REG_PORT_CFG = 12'h020;
    localparam int ENTRY_SEL_BIT = 11;
    localparam logic [3:0] F_CTRL = 4'h0;
    localparam logic [3:0] F_SRC_LO = 4'h1;
    localparam logic [3:0] F_SRC_HI = 4'h2;
    localparam logic [3:0] F_SMASK_LO = 4'h3;
    localparam logic [3:0] F_SMASK_HI = 4'h4;
    localparam logic [3:0] F_DST_LO = 4'h5;
    localparam logic [3:0] F_DST_HI = 4'h6;
    localparam logic [3:0] F_DMASK_LO = 4'h7;
    localparam logic [3:0] F_DMASK_HI = 4'h8;
    localparam int CB_PERMIT = 0;
    localparam int CB_SRC_ANY = 1;
    localparam int CB_DST_ANY = 2;
    localparam int CB_TSEL = 3;
    localparam int CB_OP = 5;
    localparam int CB_VAL = 16;
    localparam int SC_LEN = 0;
    localparam int SC_VE = 4;
    localparam int SC_LOG = 5;
    localparam int SC_COMMIT = 31;
    localparam logic [15:0] ETHERTYPE_MIN = 16'h0600;
    localparam logic [7:0] SAP_SNAP = 8'haa;
    localparam logic [7:0] LLC_UI = 8'h03;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
    typedef enum logic [1:0] {LHF_T_NONE, LHF_T_ETYPE, LHF_T_LLC, LHF_T_SNAP} lhf_tsel_t;
    typedef enum logic [1:0] {LHF_OP_EQ, LHF_OP_GT, LHF_OP_LT, LHF_OP_NEQ} lhf_op_t;
endpackage : lhf_pkg

// >>> rtl/lhf_mac_match.sv
// masked address compare with wildcard
`timescale 1ns/10ps
`default_nettype none
module lhf_mac_match #(
    parameter int W = 48
) (
    input wire logic [W-1:0] addr,
    input wire logic [W-1:0] ref_addr,
    input wire logic [W-1:0] mask,
    input wire logic any,
    output logic hit
);
    // zero mask bits are don't-care; wildcard acts as a match-all
    assign hit = any | (((addr ^ ref_addr) & mask) == '0);
endmodule : lhf_mac_match
`default_nettype wire

// >>> rtl/lhf_type_cmp.sv
// frame-type extraction and operator compare
`timescale 1ns/10ps
`default_nettype none
module lhf_type_cmp (
    input wire logic [15:0] len_type,
    input wire logic [23:0] llc,
    input wire logic [15:0] snap_type,
    input wire lhf_pkg::lhf_tsel_t tsel,
    input wire lhf_pkg::lhf_op_t op,
    input wire logic [15:0] value,
    output logic ok
);
    import lhf_pkg::*;

    function automatic logic cmp(input logic [15:0] a, input logic [15:0] b, input lhf_op_t o);
        unique case (o)
            LHF_OP_EQ: cmp = (a == b);
            LHF_OP_GT: cmp = (a > b);
            LHF_OP_LT: cmp = (a < b);
            LHF_OP_NEQ: cmp = (a != b);
        endcase
    endfunction : cmp

    logic is_etype;
    logic is_snap;
    assign is_etype = (len_type >= ETHERTYPE_MIN);
    assign is_snap = !is_etype && (llc == {SAP_SNAP, SAP_SNAP, LLC_UI});

    always_comb begin
        unique case (tsel)
            LHF_T_NONE: ok = 1'b1;
            LHF_T_ETYPE: ok = is_etype && cmp(len_type, value, op);
            LHF_T_LLC: ok = !is_etype && cmp(llc[23:8], value, op);
            // first three snap bytes skipped upstream; only its type word is seen
            LHF_T_SNAP: ok = is_snap && cmp(snap_type, value, op);
        endcase
    end
endmodule : lhf_type_cmp
`default_nettype wire

// >>> rtl/lhf_filter.sv
// layer 2 frame header filter: entry table, per-port lists, first-match walk
`timescale 1ns/10ps
`default_nettype none
module lhf_filter #(
    parameter int NUM_PORTS = 4,
    parameter int LIST_MAX = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [lhf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lhf_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lhf_pkg::DATA_W-1:0] reg_rdata,
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire logic [$clog2(NUM_PORTS)-1:0] hdr_port,
    input wire logic hdr_rx,
    input wire logic [lhf_pkg::MAC_W-1:0] hdr_dst,
    input wire logic [lhf_pkg::MAC_W-1:0] hdr_src,
    input wire logic [15:0] hdr_len_type,
    input wire logic [23:0] hdr_llc,
    input wire logic [15:0] hdr_snap_type,
    output logic vrd_valid,
    output logic vrd_permit,
    output logic vrd_drop,
    output logic vrd_log,
    output logic [lhf_pkg::ID_W-1:0] vrd_entry
);
    import lhf_pkg::*;
    localparam int PW = $clog2(NUM_PORTS);
    localparam int LW = $clog2(LIST_MAX + 1);
    localparam int SW = $clog2(LIST_MAX);

    typedef enum logic [1:0] {LHF_IDLE, LHF_WALK} lhf_state_t;

    // entry table, indexed by id minus one
    logic [DATA_W-1:0] ent_ctrl_q [ENTRY_NUM];
    logic [MAC_W-1:0] ent_src_q [ENTRY_NUM];
    logic [MAC_W-1:0] ent_smask_q [ENTRY_NUM];
    logic [MAC_W-1:0] ent_dst_q [ENTRY_NUM];
    logic [MAC_W-1:0] ent_dmask_q [ENTRY_NUM];
    // per-port lists and staging area
    logic [LIST_MAX-1:0][ID_W-1:0] port_ids_q [NUM_PORTS];
    logic [LW-1:0] port_len_q [NUM_PORTS];
    logic port_ve_q [NUM_PORTS];
    logic port_log_q [NUM_PORTS];
    logic [LIST_MAX-1:0][ID_W-1:0] stage_ids_q;
    logic [PW-1:0] stage_port_q;
    logic glob_log_q;
    logic [15:0] frames_q;
    logic [15:0] drops_q;
    // walk state
    lhf_state_t state_q;
    logic [LIST_MAX-1:0][ID_W-1:0] ids_q;
    logic [LW-1:0] len_q;
    logic [SW-1:0] pos_q;
    logic ve_q;
    logic log_q;
    logic [MAC_W-1:0] fr_src_q;
    logic [MAC_W-1:0] fr_dst_q;
    logic [15:0] fr_lt_q;
    logic [23:0] fr_llc_q;
    logic [15:0] fr_snap_q;

    function automatic logic [LW-1:0] clamp_len(input logic [3:0] n, input int lim);
        clamp_len = (int'(n) > lim) ? LW'(lim) : LW'(n);
    endfunction : clamp_len

    function automatic logic id_ok(input logic [ID_W-1:0] id);
        id_ok = (id != '0) && (int'(id) <= ENTRY_NUM);
    endfunction : id_ok

    logic ent_sel;
    logic [6:0] wr_idx;
    logic commit;
    logic accept;
    assign ent_sel = reg_addr[ENTRY_SEL_BIT];
    assign wr_idx = reg_addr[10:4];
    assign commit = reg_wr && reg_addr == REG_STAGE_CTRL && reg_wdata[SC_COMMIT];
    assign accept = hdr_valid && hdr_ready;

    // entry table writes
    always_ff @(posedge clk_sys) begin
        if (reg_wr && ent_sel) begin
            unique case (reg_addr[3:0])
                F_CTRL: ent_ctrl_q[wr_idx] <= reg_wdata;
                F_SRC_LO: ent_src_q[wr_idx][31:0] <= reg_wdata;
                F_SRC_HI: ent_src_q[wr_idx][47:32] <= reg_wdata[15:0];
                F_SMASK_LO: ent_smask_q[wr_idx][31:0] <= reg_wdata;
                F_SMASK_HI: ent_smask_q[wr_idx][47:32] <= reg_wdata[15:0];
                F_DST_LO: ent_dst_q[wr_idx][31:0] <= reg_wdata;
                F_DST_HI: ent_dst_q[wr_idx][47:32] <= reg_wdata[15:0];
                F_DMASK_LO: ent_dmask_q[wr_idx][31:0] <= reg_wdata;
                F_DMASK_HI: ent_dmask_q[wr_idx][47:32] <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // list staging and atomic commit into the port's single list
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stage_port_q <= '0;
            stage_ids_q <= '0;
            glob_log_q <= 1'b0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                port_ids_q[p] <= '0;
                port_len_q[p] <= '0;
                port_ve_q[p] <= 1'b0;
                port_log_q[p] <= 1'b0;
            end
        end else if (reg_wr && !ent_sel) begin
            if (reg_addr == REG_GLOBAL) begin
                glob_log_q <= reg_wdata[0];
            end
            if (reg_addr == REG_STAGE_PORT) begin
                stage_port_q <= reg_wdata[PW-1:0];
            end
            for (int i = 0; i < LIST_MAX; i++) begin
                if (reg_addr == REG_STAGE_ID + ADDR_W'(i)) begin
                    stage_ids_q[i] <= reg_wdata[ID_W-1:0];
                end
            end
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (reg_addr == REG_PORT_CFG + ADDR_W'(p)) begin
                    port_log_q[p] <= reg_wdata[SC_LOG];
                end
            end
            // whole list swapped in one edge; walks use their own snapshot
            if (commit) begin
                port_ids_q[stage_port_q] <= stage_ids_q;
                port_ve_q[stage_port_q] <= reg_wdata[SC_VE];
                port_log_q[stage_port_q] <= reg_wdata[SC_LOG];
                port_len_q[stage_port_q] <= reg_wdata[SC_VE]
                    ? clamp_len(reg_wdata[3:0], VE_MAX)
                    : clamp_len(reg_wdata[3:0], LIST_MAX);
            end
        end
    end

    // current entry of the walk
    logic [ID_W-1:0] cur_id;
    logic [6:0] cur_idx;
    logic cur_valid;
    logic [DATA_W-1:0] cur_ctrl;
    logic src_hit;
    logic dst_hit;
    logic type_hit;
    logic hit;
    logic last;
    assign cur_id = ids_q[pos_q];
    assign cur_idx = 7'(cur_id - 8'h01);
    assign cur_valid = id_ok(cur_id);
    assign cur_ctrl = ent_ctrl_q[cur_idx];
    assign last = (LW'(pos_q) + LW'(1)) >= len_q;

    lhf_mac_match #(.W(MAC_W)) u_src (
        .addr(fr_src_q),
        .ref_addr(ent_src_q[cur_idx]),
        .mask(ent_smask_q[cur_idx]),
        .any(cur_ctrl[CB_SRC_ANY]),
        .hit(src_hit)
    );

    lhf_mac_match #(.W(MAC_W)) u_dst (
        .addr(fr_dst_q),
        .ref_addr(ent_dst_q[cur_idx]),
        .mask(ent_dmask_q[cur_idx]),
        .any(cur_ctrl[CB_DST_ANY]),
        .hit(dst_hit)
    );

    lhf_type_cmp u_type (
        .len_type(fr_lt_q),
        .llc(fr_llc_q),
        .snap_type(fr_snap_q),
        .tsel(lhf_tsel_t'(cur_ctrl[CB_TSEL+:2])),
        .op(lhf_op_t'(cur_ctrl[CB_OP+:2])),
        .value(cur_ctrl[CB_VAL+:16]),
        .ok(type_hit)
    );

    // routing-port lists look at the source alone
    assign hit = cur_valid && src_hit && (ve_q || (dst_hit && type_hit));

    // frame capture and first-match walk
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= LHF_IDLE;
            hdr_ready <= 1'b0;
            vrd_valid <= 1'b0;
            vrd_permit <= 1'b0;
            vrd_drop <= 1'b0;
            vrd_log <= 1'b0;
            vrd_entry <= '0;
            ids_q <= '0;
            len_q <= '0;
            pos_q <= '0;
            ve_q <= 1'b0;
            log_q <= 1'b0;
            fr_src_q <= '0;
            fr_dst_q <= '0;
            fr_lt_q <= '0;
            fr_llc_q <= '0;
            fr_snap_q <= '0;
        end else begin
            vrd_valid <= 1'b0;
            unique case (state_q)
                LHF_IDLE: begin
                    hdr_ready <= 1'b1;
                    if (accept) begin
                        ids_q <= port_ids_q[hdr_port];
                        len_q <= port_len_q[hdr_port];
                        ve_q <= port_ve_q[hdr_port];
                        log_q <= glob_log_q | port_log_q[hdr_port];
                        fr_src_q <= hdr_src;
                        fr_dst_q <= hdr_dst;
                        fr_lt_q <= hdr_len_type;
                        fr_llc_q <= hdr_llc;
                        fr_snap_q <= hdr_snap_type;
                        pos_q <= '0;
                        // transmit side and list-less ports pass untouched
                        if (!hdr_rx || port_len_q[hdr_port] == '0) begin
                            vrd_valid <= 1'b1;
                            vrd_permit <= 1'b1;
                            vrd_drop <= 1'b0;
                            vrd_log <= 1'b0;
                            vrd_entry <= '0;
                        end else begin
                            hdr_ready <= 1'b0;
                            state_q <= LHF_WALK;
                        end
                    end
                end
                LHF_WALK: begin
                    if (hit || last) begin
                        vrd_valid <= 1'b1;
                        vrd_entry <= hit ? cur_id : '0;
                        if (hit && !ve_q && cur_ctrl[CB_PERMIT]) begin
                            vrd_permit <= 1'b1;
                            vrd_drop <= 1'b0;
                            vrd_log <= 1'b0;
                        end else if (!hit && ve_q) begin
                            // a deny-only list that misses lets the packet through
                            vrd_permit <= 1'b1;
                            vrd_drop <= 1'b0;
                            vrd_log <= 1'b0;
                        end else begin
                            vrd_permit <= 1'b0;
                            vrd_drop <= 1'b1;
                            vrd_log <= log_q;
                        end
                        hdr_ready <= 1'b1;
                        state_q <= LHF_IDLE;
                    end else begin
                        pos_q <= SW'(pos_q + SW'(1));
                    end
                end
                default: state_q <= LHF_IDLE;
            endcase
        end
    end

    // statistics
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            frames_q <= '0;
            drops_q <= '0;
        end else if (vrd_valid) begin
            frames_q <= frames_q + 16'h0001;
            if (vrd_drop) begin
                drops_q <= drops_q + 16'h0001;
            end
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= CTRL_RST;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (ent_sel) begin
            unique case (reg_addr[3:0])
                F_CTRL: reg_rdata <= ent_ctrl_q[wr_idx];
                F_SRC_LO: reg_rdata <= ent_src_q[wr_idx][31:0];
                F_SRC_HI: reg_rdata <= {16'h0000, ent_src_q[wr_idx][47:32]};
                F_SMASK_LO: reg_rdata <= ent_smask_q[wr_idx][31:0];
                F_SMASK_HI: reg_rdata <= {16'h0000, ent_smask_q[wr_idx][47:32]};
                F_DST_LO: reg_rdata <= ent_dst_q[wr_idx][31:0];
                F_DST_HI: reg_rdata <= {16'h0000, ent_dst_q[wr_idx][47:32]};
                F_DMASK_LO: reg_rdata <= ent_dmask_q[wr_idx][31:0];
                F_DMASK_HI: reg_rdata <= {16'h0000, ent_dmask_q[wr_idx][47:32]};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
            if (reg_addr == REG_GLOBAL) begin
                reg_rdata <= {31'h0, glob_log_q};
            end
            if (reg_addr == REG_STATUS) begin
                reg_rdata <= {28'h0, 2'(pos_q), hdr_ready, state_q == LHF_WALK};
            end
            if (reg_addr == REG_STAGE_PORT) begin
                reg_rdata <= DATA_W'(stage_port_q);
            end
            if (reg_addr == REG_FRAMES) begin
                reg_rdata <= {16'h0000, frames_q};
            end
            if (reg_addr == REG_DROPS) begin
                reg_rdata <= {16'h0000, drops_q};
            end
            for (int i = 0; i < LIST_MAX; i++) begin
                if (reg_addr == REG_STAGE_ID + ADDR_W'(i)) begin
                    reg_rdata <= DATA_W'(stage_ids_q[i]);
                end
            end
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (reg_addr == REG_PORT_CFG + ADDR_W'(p)) begin
                    reg_rdata <= DATA_W'({port_log_q[p], port_ve_q[p], 4'(port_len_q[p])});
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_first_hit_stop: assert property (state_q == LHF_WALK && hit
        |=> vrd_valid && vrd_entry == $past(cur_id))
        else $error("walk did not stop at first match");
    a_walk_bound: assert property (accept |-> ##[1:9] vrd_valid)
        else $error("verdict late");
    a_permit_action: assert property (state_q == LHF_WALK && hit && !ve_q
        |=> vrd_permit == $past(cur_ctrl[CB_PERMIT]))
        else $error("action not applied");
    a_one_verdict: assert property (vrd_valid |-> vrd_permit != vrd_drop)
        else $error("verdict not exclusive");
    a_src_mask: assert property (state_q == LHF_WALK && hit && !cur_ctrl[CB_SRC_ANY]
        |-> ((fr_src_q ^ ent_src_q[cur_idx]) & ent_smask_q[cur_idx]) == '0)
        else $error("source mask ignored");
    a_dst_mask: assert property (state_q == LHF_WALK && hit && !ve_q
        && !cur_ctrl[CB_DST_ANY]
        |-> ((fr_dst_q ^ ent_dst_q[cur_idx]) & ent_dmask_q[cur_idx]) == '0)
        else $error("destination mask ignored");
    a_wild_src: assert property (state_q == LHF_WALK && cur_ctrl[CB_SRC_ANY]
        |-> src_hit)
        else $error("wildcard missed");
    a_etype_class: assert property (state_q == LHF_WALK && hit && !ve_q
        && cur_ctrl[CB_TSEL+:2] == LHF_T_ETYPE |-> fr_lt_q >= ETHERTYPE_MIN)
        else $error("length frame took ethertype test");
    a_snap_hdr: assert property (state_q == LHF_WALK && hit && !ve_q
        && cur_ctrl[CB_TSEL+:2] == LHF_T_SNAP |-> fr_llc_q == {SAP_SNAP, SAP_SNAP, LLC_UI})
        else $error("non snap frame matched snap test");
    a_all_tests: assert property (state_q == LHF_WALK && hit && !ve_q
        |-> src_hit && dst_hit && type_hit)
        else $error("partial test matched");
    a_ve_src_only: assert property (state_q == LHF_WALK && ve_q && cur_valid
        && src_hit |=> vrd_valid && vrd_drop)
        else $error("routing list did not deny");
    // a bypass header may be taken right after the verdict, so only the verdict is judged
    a_miss_drop: assert property (state_q == LHF_WALK && !hit && last && !ve_q
        |=> vrd_valid && vrd_drop && vrd_entry == '0)
        else $error("unmatched frame passed");
    a_tx_pass: assert property (accept && !hdr_rx |=> vrd_valid && vrd_permit)
        else $error("transmit frame filtered");
    a_log_flag: assert property (vrd_valid && vrd_drop && $past(log_q)
        && $past(state_q) == LHF_WALK |-> vrd_log)
        else $error("deny not flagged");
    a_ve_len: assert property (commit && reg_wdata[SC_VE]
        |=> port_len_q[$past(stage_port_q)] <= LW'(VE_MAX))
        else $error("routing list too long");
    a_list_frozen: assert property (state_q == LHF_WALK && $past(state_q) == LHF_WALK
        |-> $stable(ids_q))
        else $error("list changed mid walk");
    c_permit_hit: cover property (vrd_valid && vrd_permit && vrd_entry != '0);
    c_ve_deny: cover property (state_q == LHF_WALK && ve_q && hit);
    c_default_drop: cover property (vrd_valid && vrd_drop && vrd_entry == '0);
endmodule : lhf_filter
`default_nettype wire

// >>> tb/lhf_rx_model.sv
// receive path model: offers one header and collects its verdict
`timescale 1ns/10ps
`default_nettype none
module lhf_rx_model (
    input wire logic clk_sys,
    input wire logic hdr_ready,
    output logic hdr_valid,
    output logic [1:0] hdr_port,
    output logic hdr_rx,
    output logic [47:0] hdr_dst,
    output logic [47:0] hdr_src,
    output logic [15:0] hdr_len_type,
    output logic [23:0] hdr_llc,
    output logic [15:0] hdr_snap_type,
    input wire logic vrd_valid,
    input wire logic vrd_permit,
    input wire logic vrd_drop,
    input wire logic vrd_log,
    input wire logic [7:0] vrd_entry
);
    initial {hdr_valid, hdr_port, hdr_rx, hdr_dst, hdr_src, hdr_len_type, hdr_llc,
        hdr_snap_type} = '0;
    task automatic send(input logic [1:0] p, input logic rx, input logic [47:0] s, d,
        input logic [15:0] lt, input logic [23:0] llc, input logic [15:0] sn,
        output logic [10:0] v, output bit ok);
        ok = 1'b0;
        @(posedge clk_sys);
        {hdr_valid, hdr_port, hdr_rx, hdr_src, hdr_dst} <= {1'b1, p, rx, s, d};
        {hdr_len_type, hdr_llc, hdr_snap_type} <= {lt, llc, sn};
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge clk_sys);
            ok = hdr_ready;
        end
        // released lines flip so a stale header cannot look valid
        {hdr_valid, hdr_src, hdr_dst} <= {1'b0, ~s, ~d};
        {hdr_len_type, hdr_llc, hdr_snap_type} <= ~{lt, llc, sn};
        for (int n = 0; n < 20 && ok; n++) begin
            @(posedge clk_sys);
            if (vrd_valid) break;
            ok = (n < 19);
        end
        v = {vrd_log, vrd_drop, vrd_permit, vrd_entry};
    endtask : send
endmodule : lhf_rx_model
`default_nettype wire

// >>> tb/lhf_filter_tb.sv
// self-checking bench of the frame header filter
`timescale 1ns/10ps
`default_nettype none
module lhf_filter_tb;
    import lhf_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata, r;
    logic hdr_valid, hdr_ready, hdr_rx, vrd_valid, vrd_permit, vrd_drop, vrd_log;
    logic [1:0] hdr_port;
    logic [47:0] hdr_dst, hdr_src;
    logic [15:0] hdr_len_type, hdr_snap_type;
    logic [23:0] hdr_llc;
    logic [7:0] vrd_entry;
    logic [79:0] tbl [10];
    int fail_count = 0;
    int n_compared = 0;
    localparam logic [47:0] DA = 48'h0a0b_0c0d_0e0f;
    always #25 clk_sys = ~clk_sys;
    lhf_filter #(.NUM_PORTS(4), .LIST_MAX(8)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
        .hdr_port(hdr_port), .hdr_rx(hdr_rx), .hdr_dst(hdr_dst), .hdr_src(hdr_src),
        .hdr_len_type(hdr_len_type), .hdr_llc(hdr_llc), .hdr_snap_type(hdr_snap_type),
        .vrd_valid(vrd_valid), .vrd_permit(vrd_permit), .vrd_drop(vrd_drop),
        .vrd_log(vrd_log), .vrd_entry(vrd_entry));
    lhf_rx_model rx (.clk_sys(clk_sys), .hdr_ready(hdr_ready), .hdr_valid(hdr_valid),
        .hdr_port(hdr_port), .hdr_rx(hdr_rx), .hdr_dst(hdr_dst), .hdr_src(hdr_src),
        .hdr_len_type(hdr_len_type), .hdr_llc(hdr_llc), .hdr_snap_type(hdr_snap_type),
        .vrd_valid(vrd_valid), .vrd_permit(vrd_permit), .vrd_drop(vrd_drop),
        .vrd_log(vrd_log), .vrd_entry(vrd_entry));
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        r = reg_rdata;
    endtask : rd
    task automatic entry(input int id, input logic [31:0] c, input logic [47:0] s, sm, d, dm);
        logic [47:0] f [4];
        f = '{s, sm, d, dm};
        wr(12'h800 | 12'((id - 1) << 4), c);
        for (int i = 0; i < 4; i++) begin
            wr(12'h800 | 12'((id - 1) << 4) | 12'(2 * i + 1), f[i][31:0]);
            wr(12'h800 | 12'((id - 1) << 4) | 12'(2 * i + 2), {16'h0, f[i][47:32]});
        end
    endtask : entry
    task automatic commit(input logic [1:0] p, input logic [7:0] ids [$], input bit ve, lg);
        wr(REG_STAGE_PORT, {30'h0, p});
        foreach (ids[i]) wr(REG_STAGE_ID + 12'(i), {24'h0, ids[i]});
        wr(REG_STAGE_CTRL, {1'b1, 25'h0, lg, ve, 4'(ids.size())});
    endtask : commit
    task automatic frm(input string w, input logic [1:0] p, input logic x, input logic [47:0] s,
        d, input logic [15:0] lt, input logic [23:0] llc, input logic [15:0] sn,
        input logic [10:0] e);
        logic [10:0] v;
        bit ok;
        rx.send(p, x, s, d, lt, llc, sn, v, ok);
        if (!ok) begin
            fail_count++;
            end_of_test();
        end
        chk(w, 32'(v), 32'(e));
    endtask : frm
    task automatic s_reset();
        rd(12'h3ff);
        chk("unmapped", r, 32'h0);
        frm("no list", 2'd0, 1'b1, 48'h3565_0000_0001, DA, 16'h0806, 24'h0, 16'h0, 11'h100);
    endtask : s_reset
    task automatic s_first();
        entry(1, {16'h0806, 16'h000c}, 48'h3565_0000_0000, 48'hffff_0000_0000, '0, '0);
        entry(2, 32'h7, '0, '0, '0, '0);
        rd(12'h802);
        chk("src hi", r, 32'h3565);
        commit(2'd0, '{8'd1, 8'd2}, 1'b0, 1'b0);
        frm("deny arp", 2'd0, 1'b1, 48'h3565_1111_2222, DA, 16'h0806, 24'h0, 16'h0, 11'h201);
        frm("ip", 2'd0, 1'b1, 48'h3565_1111_2222, DA, 16'h0800, 24'h0, 16'h0, 11'h102);
        frm("other", 2'd0, 1'b1, 48'h1234_1111_2222, DA, 16'h0806, 24'h0, 16'h0, 11'h102);
        frm("tx", 2'd0, 1'b0, 48'h3565_1111_2222, DA, 16'h0806, 24'h0, 16'h0, 11'h100);
        wr(REG_GLOBAL, 32'h1);
        frm("glog", 2'd0, 1'b1, 48'h3565_0000_0000, DA, 16'h0806, 24'h0, 16'h0, 11'h601);
        wr(REG_GLOBAL, 32'h0);
        commit(2'd0, '{8'd2}, 1'b0, 1'b0);
        frm("new list", 2'd0, 1'b1, 48'h3565_0000_0000, DA, 16'h0806, 24'h0, 16'h0, 11'h102);
    endtask : s_first
    task automatic s_types();
        tbl = '{80'h4_0800_0800_000000_0000_1, 80'h5_0800_0801_000000_0000_1,
            80'h6_0800_0800_000000_0000_0, 80'h6_0800_0700_000000_0000_1,
            80'h7_0800_0800_000000_0000_0, 80'h7_0800_0700_000000_0000_1,
            80'h8_4242_0040_424203_0000_1, 80'h8_4242_0800_424203_0000_0,
            80'hc_0806_0050_aaaa03_0806_1, 80'hc_0806_0050_aaaa00_0806_0};
        entry(3, 32'h3, '0, '0, 48'h0a0b_0cff_ffff, 48'hffff_ff00_0000);
        commit(2'd1, '{8'd3}, 1'b0, 1'b0);
        foreach (tbl[i]) begin
            wr(12'h820, {tbl[i][75:60], 9'h0, tbl[i][77:76], tbl[i][79:78], 3'b011});
            frm("type", 2'd1, 1'b1, 48'h1, DA, tbl[i][59:44], tbl[i][43:20], tbl[i][19:4],
                tbl[i][0] ? 11'h103 : 11'h200);
        end
        // type test of the last row passes here, so only the destination can fail
        frm("dst miss", 2'd1, 1'b1, 48'h1, 48'h0a0c_0c0d_0e0f, 16'h0050, 24'haaaa03, 16'h0806,
            11'h200);
    endtask : s_types
    task automatic s_route();
        commit(2'd2, '{8'd2}, 1'b1, 1'b1);
        frm("ve deny", 2'd2, 1'b1, 48'h1234_0000_0000, DA, 16'h0800, 24'h0, 16'h0, 11'h602);
        commit(2'd3, '{8'd1}, 1'b1, 1'b0);
        frm("ve src", 2'd3, 1'b1, 48'h3565_0000_0009, DA, 16'h0800, 24'h0, 16'h0, 11'h201);
        frm("ve miss", 2'd3, 1'b1, 48'h7777_0000_0000, DA, 16'h0806, 24'h0, 16'h0, 11'h100);
        commit(2'd3, '{8'd1, 8'd2, 8'd1, 8'd2, 8'd1, 8'd2, 8'd1, 8'd2, 8'd1}, 1'b1, 1'b0);
        rd(REG_PORT_CFG + 12'h3);
        chk("ve len", r, 32'h18);
        rd(REG_DROPS);
        chk("drops", r, 32'h9);
        rd(REG_FRAMES);
        chk("frames", r, 32'h15);
    endtask : s_route
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        s_reset();
        s_first();
        s_types();
        s_route();
        end_of_test();
    end
endmodule : lhf_filter_tb
`default_nettype wire
